// file: hdl/cslot_pkg.sv
// Package of register offsets, fields and reset values for the card slot block
package cslot_pkg;

  // ***********************************************************
  // Register indices and byte addresses
  // ***********************************************************
  // Printed offsets are not all multiples of four: they are indices
  localparam logic [7:0] CSLOT_IDX_MODE  = 8'h20;
  localparam logic [7:0] CSLOT_IDX_CTRL0 = 8'h21;
  localparam logic [7:0] CSLOT_IDX_IRQ_STAT = 8'h30;
  localparam logic [7:0] CSLOT_IDX_IRQ_EN   = 8'h31;
  localparam logic [7:0] CSLOT_IDX_IRQ_CLR  = 8'h32;
  localparam logic [7:0] CSLOT_IDX_CMD      = 8'h33;
  localparam logic [7:0] CSLOT_IDX_STATE    = 8'h34;
  localparam int CSLOT_ADDR_W = 10;

  // ***********************************************************
  // Mode register fields
  // ***********************************************************
  localparam int MODE_SLOT0_EN_N  = 7;
  localparam int MODE_SLOT1_EN_N  = 6;
  localparam int MODE_ROUTE_HI    = 5;
  localparam int MODE_ROUTE_LO    = 4;
  localparam int MODE_SLOT0_PROG  = 3;
  localparam int MODE_SLOT1_PROG  = 1;
  localparam logic [7:0] MODE_RESET    = 8'h70;
  localparam logic [7:0] MODE_WR_MASK  = 8'hFA;

  // ***********************************************************
  // Slot 0 control register fields
  // ***********************************************************
  localparam int CTRL_BYTE_ONLY   = 7;
  localparam int CTRL_IO_MODE     = 6;
  localparam int CTRL_COMMON_MEM  = 5;
  localparam int CTRL_CIRQ_HI     = 4;
  localparam int CTRL_CIRQ_LO     = 2;
  localparam int CTRL_DLY_HI      = 1;
  localparam int CTRL_DLY_LO      = 0;
  localparam logic [7:0] CTRL_RESET = 8'h1D;

  // ***********************************************************
  // Status event bits (also enable and clear layout)
  // ***********************************************************
  localparam int EV_CARD_CHANGE = 0;
  localparam int EV_BATT_FAIL   = 1;
  localparam int EV_BATT_LOW    = 2;
  localparam int EV_CARD_TMO    = 3;
  localparam int EV_N           = 4;

  // Status interrupt destination one-hot order: nmi, irq2, irq6, irq7
  localparam int DEST_N = 4;
  // Card interrupt one-hot order: irq2 .. irq7
  localparam int CIRQ_N = 6;

  // AXI responses
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // Command strobe delay state
  typedef enum logic [1:0] {
    CSLOT_IDLE,
    CSLOT_WAIT,
    CSLOT_FIRE
  } cslot_dly_t;

endpackage : cslot_pkg

// file: hdl/cslot_cmd_delay.sv
// Command strobe delay unit: delays a request by 1 to 4 clock cycles
`timescale 1ns/100ps
module cslot_cmd_delay
  import cslot_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request and delay setting
  input  wire logic       cmd_req,
  input  wire logic [1:0] delay,
  // Delayed strobe and busy
  output logic            cmd_strobe,
  output logic            busy
);

  cslot_dly_t state;
  logic [1:0] count;

  // Delay sequencer; requests while busy are dropped to keep one in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= CSLOT_IDLE;
      count      <= 2'd0;
      cmd_strobe <= 1'b0;
    end else begin
      cmd_strobe <= 1'b0;
      case (state)
        CSLOT_IDLE: begin
          if (cmd_req) begin
            // Every code adds one edge, so code d lands d+1 edges later
            if (delay == 2'd0) begin
              state <= CSLOT_FIRE; // Zero delay fires next edge
            end else begin
              count <= delay - 2'd1;
              state <= CSLOT_WAIT;
            end
          end
        end
        CSLOT_WAIT: begin
          if (count == 2'd0) begin
            state <= CSLOT_FIRE;
          end else begin
            count <= count - 2'd1;
          end
        end
        CSLOT_FIRE: begin
          cmd_strobe <= 1'b1;      // Strobe delay+1 cycles after the request
          state      <= CSLOT_IDLE;
        end
        default: state <= CSLOT_IDLE;
      endcase
    end
  end

  assign busy = (state != CSLOT_IDLE);

endmodule : cslot_cmd_delay

// file: hdl/cslot_ctrl.sv
// Card slot mode and slot 0 control register bank with AXI4-Lite slave
// Operation
// - Slot 0 enabled while its active-low enable bit is 0; resets 0.
// - Slot 1 enabled only while its active-low bit is 0; resets 1.
// - Two-bit field routes status interrupts to NMI, IRQ2, IRQ6, IRQ7.
// - Slot 0 programming-enable bit allows slot 0 voltage output.
// - Slot 1 programming-enable bit allows slot 1 voltage output.
// - Card removal disables that slot's programming-voltage controls; here only the output is gated, the enable bit is kept.
// - Byte-only bit carries slot 0 I/O data on low byte lanes.
// - Interface bit: 0 memory mode, 1 I/O mode; resets 0.
// - Card absent or powered off forces the interface bit to 0.
// - Memory-space bit drives slot 0 attribute select directly.
// - During DMA the attribute select output is driven high.
// - Voltage output needs enable bit, voltage valid and card present.
// - Slot enable bits gate chip-select decoding of each slot.
// - Card change, battery and timeout events go to the routed channel.
`timescale 1ns/100ps
module cslot_ctrl
  import cslot_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic [CSLOT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [CSLOT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Card side status inputs
  input  wire logic [1:0]              slot0_card_detect_n,
  input  wire logic [1:0]              slot1_card_detect_n,
  input  wire logic                    slot0_powered,
  input  wire logic                    prog_voltage_valid,
  input  wire logic                    dma_cycle,
  input  wire logic                    card_irq_request,
  input  wire logic [EV_N-1:0]         status_event,
  // Chip-select requests from the address decoder
  input  wire logic                    slot0_cs_req,
  input  wire logic                    slot1_cs_req,
  // Slot outputs
  output logic                         slot0_cs,
  output logic                         slot1_cs,
  output logic                         slot0_prog_voltage_out,
  output logic                         slot1_prog_voltage_out,
  output logic                         slot0_attr_select_n,
  output logic                         slot0_io_mode,
  output logic                         slot0_byte_only,
  output logic                         cmd_strobe,
  // Routed interrupt lines
  output logic [DEST_N-1:0]            status_irq_dest,
  output logic [CIRQ_N-1:0]            card_irq_dest,
  output logic                         irq
);

  // ***********************************************************
  // Register storage
  // ***********************************************************
  logic [7:0]      mode;
  logic [7:0]      ctrl0;
  logic [EV_N-1:0] irq_stat;
  logic [EV_N-1:0] irq_en;
  logic [EV_N-1:0] next_irq_stat;

  logic [CSLOT_ADDR_W-1:0] aw_addr;
  logic [31:0]             w_data;
  logic                    w_lane0;
  logic                    aw_held;
  logic                    w_held;
  logic [7:0]              w_idx;
  logic [7:0]              r_idx;
  logic                    do_write;
  logic                    cmd_req;
  logic                    cmd_busy;
  logic                    slot0_present;
  logic                    slot1_present;
  logic                    force_mem;

  // Card present only when both detect lines are low
  assign slot0_present = ~slot0_card_detect_n[0] & ~slot0_card_detect_n[1];
  assign slot1_present = ~slot1_card_detect_n[0] & ~slot1_card_detect_n[1];
  assign force_mem     = ~slot0_present | ~slot0_powered;

  // ***********************************************************
  // AXI write channel
  // ***********************************************************
  assign w_idx    = 8'(aw_addr >> 2);
  assign do_write = aw_held & w_held & ~s_axi_bvalid;

  // Address and data taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 32'h0000_0000;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= AXI_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (w_idx)
          CSLOT_IDX_MODE, CSLOT_IDX_CTRL0, CSLOT_IDX_IRQ_EN,
          CSLOT_IDX_IRQ_CLR, CSLOT_IDX_CMD, CSLOT_IDX_IRQ_STAT,
          CSLOT_IDX_STATE: s_axi_bresp <= AXI_OKAY;
          default:         s_axi_bresp <= AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ***********************************************************
  // Configuration registers
  // ***********************************************************
  // Mode register; reserved bits stay zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_RESET;
    end else if (do_write && w_lane0 && w_idx == CSLOT_IDX_MODE) begin
      mode <= w_data[7:0] & MODE_WR_MASK;
    end
  end

  // Slot 0 control; interface bit cleared while card is absent or off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0 <= CTRL_RESET;
    end else begin
      if (do_write && w_lane0 && w_idx == CSLOT_IDX_CTRL0) begin
        ctrl0 <= w_data[7:0];
      end
      if (force_mem) begin
        ctrl0[CTRL_IO_MODE] <= 1'b0;
      end
    end
  end

  // Interrupt enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= '0;
    end else if (do_write && w_lane0 && w_idx == CSLOT_IDX_IRQ_EN) begin
      irq_en <= w_data[EV_N-1:0];
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_comb begin
    next_irq_stat = irq_stat;
    if (do_write && w_lane0 && w_idx == CSLOT_IDX_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~w_data[EV_N-1:0];
    end
    next_irq_stat = next_irq_stat | status_event;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Command request pulse from software write to the command register
  assign cmd_req = do_write & w_lane0 & (w_idx == CSLOT_IDX_CMD);

  // ***********************************************************
  // Slot outputs
  // ***********************************************************
  // Decoding gated by active-low enables; slot 1 relies on software
  // having stopped keyboard scanning first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot0_cs <= 1'b0;
      slot1_cs <= 1'b0;
    end else begin
      slot0_cs <= slot0_cs_req & ~mode[MODE_SLOT0_EN_N];
      slot1_cs <= slot1_cs_req & ~mode[MODE_SLOT1_EN_N];
    end
  end

  // Programming voltage only with enable, valid supply and a card in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot0_prog_voltage_out <= 1'b0;
      slot1_prog_voltage_out <= 1'b0;
    end else begin
      slot0_prog_voltage_out <= mode[MODE_SLOT0_PROG] & prog_voltage_valid
                                & slot0_present;
      slot1_prog_voltage_out <= mode[MODE_SLOT1_PROG] & prog_voltage_valid
                                & slot1_present;
    end
  end

  // Slot 0 interface mode, byte lanes and attribute select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot0_io_mode       <= 1'b0;
      slot0_byte_only     <= 1'b0;
      slot0_attr_select_n <= 1'b0;
    end else begin
      slot0_io_mode   <= ctrl0[CTRL_IO_MODE] & ~force_mem;
      slot0_byte_only <= ctrl0[CTRL_BYTE_ONLY]
                         & ctrl0[CTRL_IO_MODE];
      slot0_attr_select_n <= dma_cycle ? 1'b1
                             : ctrl0[CTRL_COMMON_MEM];
    end
  end

  // ***********************************************************
  // Interrupt routing
  // ***********************************************************
  // Status interrupt goes to one destination chosen by the route field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_irq_dest <= '0;
      card_irq_dest   <= '0;
      irq             <= 1'b0;
    end else begin
      irq <= |(next_irq_stat & irq_en);
      status_irq_dest <= '0;
      status_irq_dest[mode[MODE_ROUTE_HI:MODE_ROUTE_LO]] <=
        |(next_irq_stat & irq_en);
      card_irq_dest <= '0;
      // Codes below 010 are illegal and route nowhere
      if (ctrl0[CTRL_CIRQ_HI:CTRL_CIRQ_LO] >= 3'd2) begin
        card_irq_dest[3'(ctrl0[CTRL_CIRQ_HI:CTRL_CIRQ_LO] - 3'd2)] <=
          card_irq_request & ctrl0[CTRL_IO_MODE];
      end
    end
  end

  // ***********************************************************
  // Command delay and read channel
  // ***********************************************************
  cslot_cmd_delay u_cmd_delay (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .cmd_req    (cmd_req),
    .delay      (ctrl0[CTRL_DLY_HI:CTRL_DLY_LO]),
    .cmd_strobe (cmd_strobe),
    .busy       (cmd_busy)
  );

  assign r_idx = 8'(s_axi_araddr >> 2);

  // Reads answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= AXI_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        case (r_idx)
          CSLOT_IDX_MODE:     s_axi_rdata[7:0] <= mode;
          CSLOT_IDX_CTRL0:    s_axi_rdata[7:0] <= ctrl0;
          CSLOT_IDX_IRQ_STAT: s_axi_rdata[EV_N-1:0] <= irq_stat;
          CSLOT_IDX_IRQ_EN:   s_axi_rdata[EV_N-1:0] <= irq_en;
          CSLOT_IDX_IRQ_CLR, CSLOT_IDX_CMD: ;
          CSLOT_IDX_STATE:
            s_axi_rdata[3:0] <= {cmd_busy, slot1_present,
                                 slot0_present, force_mem};
          default:            s_axi_rresp <= AXI_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : cslot_ctrl

// file: sim/cslot_card_model.sv
// Behavioural model of a card sitting in one socket
`timescale 1ns/100ps
module cslot_card_model (
  // Clock
  input  wire logic  aclk,
  // Scenario controls
  input  wire logic  inserted,
  input  wire logic  power_on,
  input  wire logic  irq_on,
  // Socket pins
  output logic [1:0] detect_n = 2'b11,
  output logic       powered  = 1'b0,
  output logic       irq_req  = 1'b0
);
  // Contacts close one at a time; pull-ups hold an empty socket high
  always_ff @(posedge aclk) begin
    detect_n <= inserted ? {1'b0, detect_n[1]} : 2'b11;
    powered  <= inserted & power_on;
  end

  // An empty socket floats its request line, so it shows noise
  always_ff @(posedge aclk) begin
    irq_req <= (detect_n == 2'b00) ? irq_on : ~irq_req;
  end
endmodule : cslot_card_model

// file: sim/cslot_ctrl_properties.sv
// Port checker for the card slot control block
`timescale 1ns/100ps
module cslot_ctrl_properties
  import cslot_pkg::*;
(
  // Clock, reset and bus handshakes
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  // Card side and slot outputs
  input wire logic [1:0]        slot0_card_detect_n,
  input wire logic              slot0_powered,
  input wire logic              prog_voltage_valid,
  input wire logic              dma_cycle,
  input wire logic              card_irq_request,
  input wire logic              slot0_cs_req,
  input wire logic              slot0_cs,
  input wire logic              slot0_prog_voltage_out,
  input wire logic              slot0_attr_select_n,
  input wire logic              slot0_io_mode,
  input wire logic              cmd_strobe,
  input wire logic [DEST_N-1:0] status_irq_dest,
  input wire logic [CIRQ_N-1:0] card_irq_dest,
  input wire logic              irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Card missing when either detect pin is high
  wire logic card_gone = (slot0_card_detect_n != 2'b00);

  // Both write channels and the read address handed over
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_wr_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_cs_gated: assert property (
    slot0_cs |-> $past(slot0_cs_req)) else $error("select without hit");
  chk_vpp_cond: assert property (
    (!prog_voltage_valid || card_gone)[*2] |-> !slot0_prog_voltage_out)
    else $error("voltage enable without card or supply");
  chk_io_forced: assert property (
    (card_gone || !slot0_powered)[*3] |-> !slot0_io_mode)
    else $error("io mode not forced off");
  chk_attr_dma: assert property (dma_cycle |=> slot0_attr_select_n)
    else $error("attribute select low in dma");
  chk_cirq_cause: assert property (
    card_irq_dest != '0 |-> $past(card_irq_request))
    else $error("card interrupt without request");
  chk_cirq_onehot: assert property ($onehot0(card_irq_dest))
    else $error("card interrupt on two lines");
  chk_irq_route: assert property (
    irq == (status_irq_dest != '0) && $onehot0(status_irq_dest))
    else $error("status routing disagrees with irq");
  chk_strobe_pulse: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("strobe longer than a cycle");
endmodule : cslot_ctrl_properties

bind cslot_ctrl cslot_ctrl_properties u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .slot0_card_detect_n,
  .slot0_powered, .prog_voltage_valid, .dma_cycle, .card_irq_request,
  .slot0_cs_req, .slot0_cs, .slot0_prog_voltage_out, .slot0_attr_select_n,
  .slot0_io_mode, .cmd_strobe, .status_irq_dest, .card_irq_dest, .irq
);

// file: sim/tb_cslot_ctrl.sv
// Self-checking bench for the card slot mode and control registers
`timescale 1ns/100ps
module tb_cslot_ctrl;
  import cslot_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, slot0_powered;
  logic [CSLOT_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [1:0] slot0_card_detect_n, slot1_card_detect_n;
  logic prog_voltage_valid, dma_cycle, card_irq_request, slot0_cs_req;
  logic slot1_cs_req, slot0_cs, slot1_cs, slot0_prog_voltage_out;
  logic slot1_prog_voltage_out, slot0_attr_select_n, slot0_io_mode;
  logic slot0_byte_only, cmd_strobe, irq, ins0, ins1, pon0, irq_on;
  logic [EV_N-1:0] status_event;
  logic [DEST_N-1:0] status_irq_dest;
  logic [CIRQ_N-1:0] card_irq_dest;
  int errors, n_compared, cyc, t_b, t_s;

  cslot_ctrl uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .slot0_card_detect_n, .slot1_card_detect_n, .slot0_powered,
    .prog_voltage_valid, .dma_cycle, .card_irq_request, .status_event,
    .slot0_cs_req, .slot1_cs_req, .slot0_cs, .slot1_cs,
    .slot0_prog_voltage_out, .slot1_prog_voltage_out, .slot0_attr_select_n,
    .slot0_io_mode, .slot0_byte_only, .cmd_strobe, .status_irq_dest,
    .card_irq_dest, .irq
  );
  cslot_card_model card0 (.aclk, .inserted(ins0), .power_on(pon0),
    .irq_on, .detect_n(slot0_card_detect_n), .powered(slot0_powered),
    .irq_req(card_irq_request));
  cslot_card_model card1 (.aclk, .inserted(ins1), .power_on(1'b1),
    .irq_on(1'b0), .detect_n(slot1_card_detect_n), .powered(), .irq_req());

  // Clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Cycle count, strobe time stamp and hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cmd_strobe) t_s <= cyc;
    if (cyc == 5000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // Write one register; offers address and data together
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] st = 4'h1);
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    while (!s_axi_bvalid) @(posedge aclk);
    resp = s_axi_bresp;
    t_b = cyc;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read one register; ready is raised late to make the slave wait
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                     input logic [1:0] er = AXI_OKAY);
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk(s_axi_rdata, {24'h00_0000, exp});
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask : rdc

  // One-cycle pulse on a status event input
  task automatic fire(input int b);
    @(posedge aclk);
    status_event <= EV_N'(1 << b);
    @(posedge aclk);
    status_event <= '0;
  endtask : fire

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, prog_voltage_valid, dma_cycle} = '0;
    {slot0_cs_req, slot1_cs_req, status_event} = '0;
    {ins0, ins1, pon0, irq_on} = '0;
    {errors, n_compared, cyc, t_b, t_s} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(CSLOT_IDX_MODE, 8'h70);
    rdc(CSLOT_IDX_CTRL0, 8'h1D);
    rdc(8'h22, 8'h00, AXI_SLVERR);
    wr(8'h22, 8'h55);
    chk(32'(resp), 32'(AXI_SLVERR));
    slot0_cs_req <= 1'b1;
    slot1_cs_req <= 1'b1;
    tick(2);
    chk(32'(slot0_cs), 1);
    chk(32'(slot1_cs), 0);
    wr(CSLOT_IDX_MODE, 8'hB0); // keyboard scan taken as off
    tick(2);
    chk(32'(slot0_cs), 0);
    chk(32'(slot1_cs), 1);
    {ins0, ins1, pon0, prog_voltage_valid} <= 4'hF;
    wr(CSLOT_IDX_MODE, 8'h3F);
    tick(3);
    rdc(CSLOT_IDX_MODE, 8'h3A);
    chk(32'(slot0_prog_voltage_out), 1);
    chk(32'(slot1_prog_voltage_out), 1);
    prog_voltage_valid <= 1'b0;
    tick(3);
    chk(32'(slot0_prog_voltage_out), 0);
    prog_voltage_valid <= 1'b1;
    ins0 <= 1'b0;
    tick(3);
    chk(32'(slot0_prog_voltage_out), 0);
    chk(32'(slot1_prog_voltage_out), 1);
    ins0 <= 1'b1;
    tick(4);
    wr(CSLOT_IDX_CTRL0, 8'hDD);
    tick(2);
    chk(32'(slot0_io_mode), 1);
    chk(32'(slot0_byte_only), 1);
    chk(32'(slot0_attr_select_n), 0);
    pon0 <= 1'b0;
    tick(4);
    chk(32'(slot0_io_mode), 0);
    rdc(CSLOT_IDX_CTRL0, 8'h9D);
    pon0 <= 1'b1;
    irq_on <= 1'b1;
    tick(3);
    // Codes 000 and 001 are illegal and must route nowhere
    for (int c = 0; c < 8; c++) begin
      wr(CSLOT_IDX_CTRL0, {3'b011, 3'(c), 2'b01});
      tick(3);
      chk(32'(card_irq_dest), (c < 2) ? '0 : 32'(1 << (c - 2)));
      chk(32'(slot0_attr_select_n), 1);
    end
    wr(CSLOT_IDX_CTRL0, 8'h5D);
    tick(2);
    chk(32'(slot0_attr_select_n), 0);
    dma_cycle <= 1'b1;
    tick(2);
    chk(32'(slot0_attr_select_n), 1);
    dma_cycle <= 1'b0;
    wr(CSLOT_IDX_IRQ_EN, 8'h0F);
    for (int r = 0; r < 4; r++) begin
      wr(CSLOT_IDX_MODE, {2'b00, 2'(r), 4'h0});
      fire(r);
      tick(3);
      chk(32'(status_irq_dest), 32'(1 << r));
      chk(32'(irq), 1);
      rdc(CSLOT_IDX_IRQ_STAT, 8'(1 << r));
      wr(CSLOT_IDX_IRQ_CLR, 8'(1 << r));
      tick(2);
      chk(32'(irq), 0);
    end
    wr(CSLOT_IDX_IRQ_EN, 8'h00);
    fire(1);
    tick(3);
    chk(32'(irq), 0);
    rdc(CSLOT_IDX_IRQ_STAT, 8'h02);
    for (int d = 0; d < 4; d++) begin
      wr(CSLOT_IDX_CTRL0, {6'b000111, 2'(d)});
      wr(CSLOT_IDX_CMD, 8'h01);
      tick(8);
      chk(32'(t_s - t_b), 32'(d + 1));
    end
    // A write with byte lane 0 off must change nothing
    wr(CSLOT_IDX_CTRL0, 8'h00, 4'h0);
    chk(32'(resp), 32'(AXI_OKAY));
    rdc(CSLOT_IDX_CTRL0, 8'h1F);
    summarize();
  end
endmodule : tb_cslot_ctrl
